// ### src/dsr_top.sv
// Function
// [R1] Controller switches burst to distributed refresh right after the burst phase.
// [R2] Controller counts self refresh as distributed refresh; burst before and after.
// [R3] Self refresh entry: CKE low, CS low, CA0 CA1 low, CA2 high.
// [R4] Controller holds CKE high before entry, NOP after, CKE low throughout.
// [R5] In self refresh only CKE is watched; internal timer keeps data.
// [R6] Device refreshes within min residency; controller stays in at least that long.
// [R7] Clock may stop after entry; two stable cycles needed before exit.
// [R8] Controller holds CKE high and sends NOPs during the exit interval.
// [R9] Exit interval counts from first rising edge with CKE high.
// [R10] Controller issues one refresh after exit before the next entry.
// [R11] Controller idles all banks before self refresh entry.
// [R12] Eight banks; an 8-bit mask register holds one bit per bank.
// [R13] Masked bank (bit one) is not refreshed during self refresh.
// [R14] Eight segment mask bits apply across banks; both masks must be clear.
// [R15] Mode read decode: CS low, CA0-2 low, CA3 high; address rise plus fall.
// [R16] Register data on DQ[7:0] first beat, read latency after command.
// [R17] All strobes toggle through the burst; reserved registers give filler.
// [R18] Mode read is always a four beat burst, never interrupted.
// [R19] Controller sends only NOPs during the two-cycle mode read period.
// [R20] Controller spaces mode read to later writes by the given latency.
// [R21] Controller never cuts read or write bursts with a mode read.
// [R22] Controller waits half a burst after a read before a mode read.
// [R23] Per-bank refresh counter returns to zero at every self refresh exit.
// [R24] Controller meets the minimum refresh count per 32 ms window.
// [R25] Controller keeps a refresh credit counter adjusted after exit.
module dsr_top (
    input  wire logic                 sys_clk,
    input  wire logic                 rstn,
    input  wire logic                 link_clk,
    input  wire dsr_pkg::dsr_ca_bus_t cmd_bus,
    output dsr_pkg::dsr_dq_t          dq_out,
    output dsr_pkg::dsr_refresh_t     refresh,
    output logic [2:0]                pb_bank,
    output logic                      in_self_refresh
);

    localparam int rl_lat   = int'(dsr_pkg::READ_LATENCY) + 1;
    localparam int xsr_lim  = int'(dsr_pkg::XSR_CYC);

    dsr_pkg::dsr_link_s_t s;
    dsr_pkg::dsr_link_s_t next_s;
    dsr_pkg::dsr_cmd_t    cmd;
    logic [7:0]           addr;
    logic                 half;
    logic [9:0]           ca_fall;
    logic                 ack_sys;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------

    // Value of one burst beat on the data lines
    function automatic logic [dsr_pkg::DQ_W-1:0] beat_val(
        input logic       cal,
        input logic [3:0] pat,
        input logic [7:0] word,
        input logic [1:0] idx
    );
        logic [dsr_pkg::DQ_W-1:0] v;
        v = '0;
        if (cal)
            v = {dsr_pkg::DQ_W{pat[dsr_pkg::BEAT_LAST - idx]}};
        else if (idx == dsr_pkg::BEAT_FIRST)
            v = {{(dsr_pkg::DQ_W - dsr_pkg::MR_W){1'b0}}, word};
        return v;
    endfunction

    // Test for a calibration register address
    function automatic logic is_cal(input logic [7:0] a);
        return (a == dsr_pkg::MR_CAL_A) || (a == dsr_pkg::MR_CAL_B);
    endfunction

    // ----------------------------------------------------------------
    // Falling edge address capture
    // ----------------------------------------------------------------

    // Second half of each command arrives on the falling edge
    always_ff @(negedge link_clk or negedge rstn)
    begin
        if (!rstn)
            ca_fall <= '0;
        else
            ca_fall <= cmd_bus.ca;
    end

    // ----------------------------------------------------------------
    // Link side command engine
    // ----------------------------------------------------------------

    // Decode, self refresh sequencing, mode register access
    always_comb
    begin
        next_s          = s;
        cmd             = dsr_pkg::CMD_NONE;
        addr            = {s.pend_hi, ca_fall[1:0]}; // [R15]
        half            = (s.mrr_cyc != dsr_pkg::READ_LATENCY);
        next_s.cke_q    = cmd_bus.cke; // [R4]
        next_s.ack_sync = {s.ack_sync[0], ack_sys};
        next_s.pend     = 1'b0;

        // Second cycle of a mode register access, inside the NOP period
        if (s.pend) // [R19]
        begin
            if (s.pend_wr)
            begin
                if (addr == dsr_pkg::MR_BANK_MASK)
                    next_s.bank_mask = ca_fall[9:2]; // [R12]
                else if (addr == dsr_pkg::MR_SEG_MASK && dsr_pkg::DENSITY_1G)
                    next_s.seg_mask = ca_fall[9:2]; // [R14]
            end
            else
            begin
                // Write-only and reserved registers return zero filler
                next_s.mrr_word = (addr == dsr_pkg::MR_STATUS)
                                ? {s.pb_bank, 4'h0, s.ack_sync[1]}
                                : dsr_pkg::MASK_NONE; // [R17]
                next_s.cal      = is_cal(addr);
                next_s.cal_pat  = (addr == dsr_pkg::MR_CAL_A)
                                ? dsr_pkg::CAL_PAT_A
                                : dsr_pkg::CAL_PAT_B;
            end
        end

        // Mode register read burst, two beats per link cycle
        if (s.mrr_busy)
        begin
            next_s.mrr_cyc = s.mrr_cyc + 3'h1;
            if (s.mrr_cyc == dsr_pkg::BURST_END)
            begin
                next_s.mrr_busy = 1'b0;
                next_s.dq       = '0;
            end
            else if (s.mrr_cyc >= dsr_pkg::READ_LATENCY) // [R16]
            begin
                next_s.dq.oe        = 1'b1;
                next_s.dq.strobe_oe = 1'b1; // [R17]
                next_s.dq.rise      = beat_val(s.cal, s.cal_pat, s.mrr_word,
                                               {half, 1'b0}); // [R18]
                next_s.dq.fall      = beat_val(s.cal, s.cal_pat, s.mrr_word,
                                               {half, 1'b1});
            end
        end

        // Link state machine
        case (s.st)
            dsr_pkg::LK_ACTIVE:
            begin
                cmd = dsr_pkg::dsr_decode(cmd_bus, s.cke_q); // [R3]
            end
            dsr_pkg::LK_SELF_REF:
            begin
                // Clock may be stopped here; nothing but CKE matters
                if (cmd_bus.cke) // [R5] [R7]
                begin
                    next_s.st      = dsr_pkg::LK_EXIT;
                    next_s.sr_lvl  = 1'b0;
                    next_s.xsr_cnt = dsr_pkg::XSR_CYC - 4'h1; // [R9]
                    next_s.pb_bank = '0; // [R23]
                end
            end
            dsr_pkg::LK_EXIT:
            begin
                // Inputs ignored until the exit interval is over
                if (s.xsr_cnt != '0) // [R8]
                begin
                    next_s.xsr_cnt = s.xsr_cnt - 4'h1;
                end
                else
                begin
                    next_s.st = dsr_pkg::LK_ACTIVE;
                    cmd       = dsr_pkg::dsr_decode(cmd_bus, s.cke_q);
                end
            end
            default:
            begin
                next_s.st = dsr_pkg::LK_ACTIVE;
            end
        endcase

        // Command effects
        if (cmd == dsr_pkg::CMD_SRE) // [R3]
        begin
            next_s.st     = dsr_pkg::LK_SELF_REF;
            next_s.sr_lvl = 1'b1;
        end
        else if (cmd == dsr_pkg::CMD_MRR || cmd == dsr_pkg::CMD_MRW)
        begin
            next_s.pend    = 1'b1;
            next_s.pend_wr = (cmd == dsr_pkg::CMD_MRW);
            next_s.pend_hi = cmd_bus.ca[9:4]; // [R15]
            if (cmd == dsr_pkg::CMD_MRR)
            begin
                next_s.mrr_busy = 1'b1;
                next_s.mrr_cyc  = 3'h1;
            end
        end
        else if (cmd == dsr_pkg::CMD_REF_AB)
        begin
            next_s.pb_bank = '0;
        end
        else if (cmd == dsr_pkg::CMD_REF_PB)
        begin
            // Round robin over all banks
            next_s.pb_bank = (s.pb_bank == 3'(dsr_pkg::NUM_BANKS - 1))
                           ? 3'h0 : s.pb_bank + 3'h1;
        end
    end

    // State register on the link clock
    always_ff @(posedge link_clk or negedge rstn)
    begin
        if (!rstn)
            s <= '0;
        else
            s <= next_s;
    end

    // ----------------------------------------------------------------
    // Self refresh timer in the system clock domain
    // ----------------------------------------------------------------
    dsr_srf_engine u_engine (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .sr_req    (s.sr_lvl),
        .bank_mask (s.bank_mask),
        .seg_mask  (s.seg_mask),
        .refresh   (refresh),
        .ack       (ack_sys)
    );

    // Outputs straight from state flops
    assign dq_out          = s.dq;
    assign pb_bank         = s.pb_bank;
    assign in_self_refresh = s.sr_lvl;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_burst;
        (s.dq.oe && s.dq.strobe_oe) [*2] ##1 !s.dq.oe;
    endsequence

    sequence s_exit_start;
        s.st == dsr_pkg::LK_SELF_REF && cmd_bus.cke;
    endsequence

    property p_sre_entry;
        @(posedge link_clk) disable iff (!rstn)
        (s.st == dsr_pkg::LK_ACTIVE && s.cke_q && !cmd_bus.cke && !cmd_bus.cs_n
         && cmd_bus.ca[2:0] == dsr_pkg::CA_REF)
        |=> (s.st == dsr_pkg::LK_SELF_REF && s.sr_lvl);
    endproperty
    a_sre_entry: assert property (p_sre_entry) // [R3]
        else $error("self refresh entry not taken");

    property p_sr_hold;
        @(posedge link_clk) disable iff (!rstn)
        (s.st == dsr_pkg::LK_SELF_REF && !cmd_bus.cke)
        |=> (s.st == dsr_pkg::LK_SELF_REF && $stable(s.bank_mask) && !s.pend);
    endproperty
    a_sr_hold: assert property (p_sr_hold) // [R5]
        else $error("input acted on during self refresh");

    property p_exit_len;
        @(posedge link_clk) disable iff (!rstn)
        s_exit_start |=> s.st == dsr_pkg::LK_EXIT ##xsr_lim
                         s.st == dsr_pkg::LK_ACTIVE;
    endproperty
    a_exit_len: assert property (p_exit_len) // [R9]
        else $error("exit interval length wrong");

    property p_bank_ctr_clear;
        @(posedge link_clk) disable iff (!rstn)
        s_exit_start |=> (s.pb_bank == 3'h0 && !s.sr_lvl);
    endproperty
    a_bank_ctr_clear: assert property (p_bank_ctr_clear) // [R23]
        else $error("bank counter not cleared at exit");

    property p_mrr_burst;
        @(posedge link_clk) disable iff (!rstn)
        (cmd == dsr_pkg::CMD_MRR) |-> ##rl_lat s_burst;
    endproperty
    a_mrr_burst: assert property (p_mrr_burst) // [R18]
        else $error("mode read burst length or latency wrong");

    property p_beat0;
        @(posedge link_clk) disable iff (!rstn)
        ($rose(s.dq.oe) && !s.cal)
        |-> (s.dq.rise[7:0] == s.mrr_word && s.dq.fall == '0);
    endproperty
    a_beat0: assert property (p_beat0) // [R16]
        else $error("first beat does not carry register data");

    property p_mrr_addr;
        @(posedge link_clk) disable iff (!rstn)
        (cmd == dsr_pkg::CMD_MRR)
        |=> (s.pend && !s.pend_wr && s.pend_hi == $past(cmd_bus.ca[9:4]));
    endproperty
    a_mrr_addr: assert property (p_mrr_addr) // [R15]
        else $error("mode read address not captured");

    property p_mrw_bank;
        @(posedge link_clk) disable iff (!rstn)
        (s.pend && s.pend_wr && addr == dsr_pkg::MR_BANK_MASK)
        |=> s.bank_mask == $past(ca_fall[9:2]);
    endproperty
    a_mrw_bank: assert property (p_mrw_bank) // [R12]
        else $error("bank mask not written");

    property p_mrw_seg;
        @(posedge link_clk) disable iff (!rstn)
        (s.pend && s.pend_wr && addr == dsr_pkg::MR_SEG_MASK)
        |=> s.seg_mask == $past(ca_fall[9:2]);
    endproperty
    a_mrw_seg: assert property (p_mrw_seg) // [R14]
        else $error("segment mask not written");

    property p_pb_step;
        @(posedge link_clk) disable iff (!rstn)
        (cmd == dsr_pkg::CMD_REF_PB) |=> (s.pb_bank == $past(s.pb_bank) + 3'h1);
    endproperty
    a_pb_step: assert property (p_pb_step) // [R23]
        else $error("bank counter did not step");

    property p_ab_clear;
        @(posedge link_clk) disable iff (!rstn)
        (cmd == dsr_pkg::CMD_REF_AB) |=> (s.pb_bank == 3'h0);
    endproperty
    a_ab_clear: assert property (p_ab_clear) // [R10]
        else $error("all-bank refresh kept bank counter");

    property p_strobe_with_data;
        @(posedge link_clk) disable iff (!rstn)
        s.dq.oe |-> s.dq.strobe_oe;
    endproperty
    a_strobe_with_data: assert property (p_strobe_with_data) // [R17]
        else $error("data driven without strobe");

    property p_cal_lines;
        @(posedge link_clk) disable iff (!rstn)
        (s.dq.oe && s.cal)
        |-> ((s.dq.rise == '0 || s.dq.rise == '1) && (s.dq.fall == '0 || s.dq.fall == '1));
    endproperty
    a_cal_lines: assert property (p_cal_lines) // [R16]
        else $error("calibration lines differ");

endmodule // dsr_top

// ### src/dsr_pkg.sv
package dsr_pkg;

    // ----------------------------------------------------------------
    // Clock rates and timing
    // ----------------------------------------------------------------
    localparam int SYS_CLK_NS  = 100;
    localparam int LINK_CLK_NS = 160;
    localparam int CKESR_NS    = 1000;  // Min self refresh residency
    localparam int XSR_NS      = 140;   // Self refresh exit interval
    localparam int REFI_NS     = 7800;  // Internal refresh spacing

    // Residency and refresh spacing round down, exit interval rounds up; residency and exit never below one
    localparam int CKESR_CYC =
        (CKESR_NS / SYS_CLK_NS < 1) ? 1 : CKESR_NS / SYS_CLK_NS;
    localparam int XSR_INT =
        (XSR_NS + LINK_CLK_NS - 1) / LINK_CLK_NS;
    localparam logic [3:0] XSR_CYC  = 4'((XSR_INT < 1) ? 1 : XSR_INT);
    localparam logic [7:0] REFI_CYC = 8'(REFI_NS / SYS_CLK_NS);

    // ----------------------------------------------------------------
    // Mode register read burst and data layout
    // ----------------------------------------------------------------
    localparam logic [2:0] READ_LATENCY  = 3'h3;
    localparam logic [2:0] MRR_BURST_CYC = 3'h2;  // Four beats, two cycles
    localparam logic [2:0] BURST_END     = 3'(READ_LATENCY + MRR_BURST_CYC);
    localparam logic [1:0] BEAT_LAST     = 2'h3;
    localparam logic [1:0] BEAT_FIRST    = 2'h0;
    localparam int         DQ_W          = 16;
    localparam int         MR_W          = 8;

    // ----------------------------------------------------------------
    // Device organisation and mode register map
    // ----------------------------------------------------------------
    localparam int         NUM_BANKS    = 8;
    localparam logic       DENSITY_1G   = 1'b1;
    localparam logic [7:0] BANK_VALID   = 8'hFF;
    localparam logic [7:0] ALL_SEGS     = 8'hFF;
    localparam logic [7:0] MASK_NONE    = 8'h00;
    localparam logic [7:0] MR_BANK_MASK = 8'h10;
    localparam logic [7:0] MR_SEG_MASK  = 8'h11;
    localparam logic [7:0] MR_STATUS    = 8'h1F;
    localparam logic [7:0] MR_CAL_A     = 8'h20;
    localparam logic [7:0] MR_CAL_B     = 8'h28;
    localparam logic [3:0] CAL_PAT_A    = 4'hA;   // Beat 0 in bit 3
    localparam logic [3:0] CAL_PAT_B    = 4'h3;

    // Command codes on the low address lines
    localparam logic [2:0] CA_REF = 3'h4;
    localparam logic [3:0] CA_MRR = 4'h8;
    localparam logic [3:0] CA_MRW = 4'h0;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_NONE   = 3'b000,
        CMD_SRE    = 3'b001,
        CMD_MRR    = 3'b010,
        CMD_MRW    = 3'b011,
        CMD_REF_AB = 3'b100,
        CMD_REF_PB = 3'b101
    } dsr_cmd_t;

    typedef enum logic [1:0] {
        LK_ACTIVE   = 2'b00,
        LK_SELF_REF = 2'b01,
        LK_EXIT     = 2'b10
    } dsr_link_st_t;

    typedef struct packed {
        logic       cke;
        logic       cs_n;
        logic [9:0] ca;
    } dsr_ca_bus_t;

    typedef struct packed {
        logic            oe;
        logic            strobe_oe;
        logic [DQ_W-1:0] rise;
        logic [DQ_W-1:0] fall;
    } dsr_dq_t;

    typedef struct packed {
        logic       pulse;
        logic [7:0] bank_en;
        logic [7:0] seg_en;
    } dsr_refresh_t;

    typedef struct packed {
        logic [1:0]   sync;
        logic         live;
        logic [7:0]   timer;
        logic         ack;
        dsr_refresh_t rf;
    } dsr_eng_s_t;

    typedef struct packed {
        dsr_link_st_t st;
        logic         cke_q;
        logic         sr_lvl;
        logic         pend;
        logic         pend_wr;
        logic [5:0]   pend_hi;
        logic         mrr_busy;
        logic [2:0]   mrr_cyc;
        logic         cal;
        logic [3:0]   cal_pat;
        logic [7:0]   mrr_word;
        logic [3:0]   xsr_cnt;
        logic [2:0]   pb_bank;
        logic [7:0]   bank_mask;
        logic [7:0]   seg_mask;
        logic [1:0]   ack_sync;
        dsr_dq_t      dq;
    } dsr_link_s_t;

    // Command decode on a rising edge
    function automatic dsr_cmd_t dsr_decode(input dsr_ca_bus_t b, input logic cke_q);
        dsr_cmd_t c;
        c = CMD_NONE;
        if (!cke_q || b.cs_n)
            c = CMD_NONE;
        else if (b.ca[2:0] == CA_REF)
            c = !b.cke ? CMD_SRE : (b.ca[3] ? CMD_REF_AB : CMD_REF_PB);
        else if (!b.cke)
            c = CMD_NONE;
        else if (b.ca[3:0] == CA_MRR)
            c = CMD_MRR;
        else if (b.ca[3:0] == CA_MRW)
            c = CMD_MRW;
        return c;
    endfunction

endpackage

// ### src/dsr_srf_engine.sv
module dsr_srf_engine (
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    input  wire logic             sr_req,
    input  wire logic [7:0]       bank_mask,
    input  wire logic [7:0]       seg_mask,
    output dsr_pkg::dsr_refresh_t refresh,
    output logic                  ack
);

    localparam int ckesr_lim = dsr_pkg::CKESR_CYC;

    dsr_pkg::dsr_eng_s_t s;
    dsr_pkg::dsr_eng_s_t next_s;

    // ----------------------------------------------------------------
    // Internal self refresh timer
    // ----------------------------------------------------------------

    // Masks are static while self refresh is requested, so they are
    // latched once when the synchronised request rises
    always_comb
    begin
        next_s          = s;
        next_s.sync     = {s.sync[0], sr_req};
        next_s.live     = s.sync[1];
        next_s.rf.pulse = 1'b0;
        if (s.sync[1] && !s.live)
        begin
            next_s.rf.bank_en = ~bank_mask & dsr_pkg::BANK_VALID; // [R12] [R13]
            next_s.rf.seg_en  = dsr_pkg::DENSITY_1G ? ~seg_mask
                                                    : dsr_pkg::ALL_SEGS; // [R14]
            next_s.rf.pulse   = 1'b1; // [R6]
            next_s.timer      = dsr_pkg::REFI_CYC - 8'h01;
            next_s.ack        = 1'b1;
        end
        else if (s.sync[1])
        begin
            // Own timer keeps refreshing, no link clock needed
            if (s.timer == '0)
            begin
                next_s.rf.pulse = 1'b1; // [R5]
                next_s.timer    = dsr_pkg::REFI_CYC - 8'h01;
            end
            else
            begin
                next_s.timer = s.timer - 8'h01;
            end
        end
        else if (s.live)
        begin
            next_s.ack = 1'b0;
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            s <= '0;
        else
            s <= next_s;
    end

    assign refresh = s.rf;
    assign ack     = s.ack;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_entry_refresh;
        @(posedge sys_clk) disable iff (!rstn)
        $rose(s.sync[1]) |-> ##[1:ckesr_lim] s.rf.pulse;
    endproperty
    a_entry_refresh: assert property (p_entry_refresh) // [R6]
        else $error("no internal refresh after self refresh entry");

    property p_bank_block;
        @(posedge sys_clk) disable iff (!rstn)
        s.rf.pulse |-> ((s.rf.bank_en & bank_mask) == dsr_pkg::MASK_NONE);
    endproperty
    a_bank_block: assert property (p_bank_block) // [R13]
        else $error("masked bank enabled for refresh");

    property p_seg_block;
        @(posedge sys_clk) disable iff (!rstn)
        s.rf.pulse |-> ((s.rf.seg_en & seg_mask) == dsr_pkg::MASK_NONE);
    endproperty
    a_seg_block: assert property (p_seg_block) // [R14]
        else $error("masked segment enabled for refresh");

    property p_pulse_in_sr;
        @(posedge sys_clk) disable iff (!rstn)
        s.rf.pulse |-> $past(s.sync[1]) ##1 !s.rf.pulse;
    endproperty
    a_pulse_in_sr: assert property (p_pulse_in_sr) // [R5]
        else $error("refresh pulse outside self refresh");

endmodule // dsr_srf_engine

// ### testbench/dsr_ctrl_model.sv
// --------------------------------------------------------------------
// Controller side of the command/address link
// --------------------------------------------------------------------
module dsr_ctrl_model (
    output logic                 link_clk,
    output dsr_pkg::dsr_ca_bus_t cmd_bus
);
    timeunit 1ns;
    timeprecision 1ns;

    logic run;

    // Link clock, parks low while halted in self refresh
    initial
    begin
        link_clk = 1'b0;
        run      = 1'b1;
        cmd_bus  = '{cke: 1'b1, cs_n: 1'b1, ca: 10'h000};
        #37;
        forever
        begin
            #80;
            if (run || link_clk)
                link_clk = ~link_clk;
        end
    end

    // One command cycle, then a NOP; the falling half stands at the
    // falling edge of the NOP cycle that follows the command
    task automatic send(input logic cke, input logic cs_n, input logic [9:0] rise,
                        input logic [9:0] fall, input logic cke_after);
        @(posedge link_clk);
        cmd_bus <= '{cke: cke, cs_n: cs_n, ca: rise};
        @(posedge link_clk);
        cmd_bus <= '{cke: cke_after, cs_n: 1'b1, ca: fall};
    endtask

    // Clock may stop once entry is registered, restarts before exit
    task automatic halt();
        run = 1'b0;
    endtask

    task automatic resume();
        run = 1'b1;
    endtask
endmodule // dsr_ctrl_model

// ### testbench/tb_top.sv
// --------------------------------------------------------------------
// Self-checking bench
// --------------------------------------------------------------------
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [7:0] BANK_M = 8'h82;
    localparam logic [7:0] SEG_M  = 8'h84;

    logic                  sys_clk;
    logic                  rstn;
    logic                  link_clk;
    dsr_pkg::dsr_ca_bus_t  cmd_bus;
    dsr_pkg::dsr_dq_t      dq_out;
    dsr_pkg::dsr_refresh_t refresh;
    logic [2:0]            pb_bank;
    logic                  in_self_refresh;
    int                    n_fail;
    int                    samples_checked;
    int                    cyc;

    dsr_ctrl_model i_ctrl (.link_clk(link_clk), .cmd_bus(cmd_bus));

    dsr_top i_dut (
        .sys_clk(sys_clk), .rstn(rstn), .link_clk(link_clk), .cmd_bus(cmd_bus),
        .dq_out(dq_out), .refresh(refresh), .pb_bank(pb_bank),
        .in_self_refresh(in_self_refresh)
    );

    // System clock
    initial
    begin
        sys_clk = 1'b0;
        forever
            #50 sys_clk = ~sys_clk;
    end

    // Hang guard
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Mode read, then burst timing and beats
    task automatic mrr_chk(input logic [7:0] a, input logic [15:0] r0, input logic [15:0] f0,
                           input logic [15:0] r1, input logic [15:0] f1);
        i_ctrl.send(1'b1, 1'b0, {a[7:2], 4'h8}, {8'h00, a[1:0]}, 1'b1);
        repeat (2) @(posedge link_clk);
        #1 chk(16'(dq_out.oe), 16'h0000);
        @(posedge link_clk);
        #1 chk(16'({dq_out.oe, dq_out.strobe_oe}), 16'h0003);
        chk(dq_out.rise, r0);
        chk(dq_out.fall, f0);
        @(posedge link_clk);
        #1 chk(16'({dq_out.oe, dq_out.strobe_oe}), 16'h0003);
        chk(dq_out.rise, r1);
        chk(dq_out.fall, f1);
        @(posedge link_clk);
        #1 chk(16'(dq_out.oe), 16'h0000);
    endtask

    task automatic mode_reg_write(input logic [7:0] a, input logic [7:0] d);
        i_ctrl.send(1'b1, 1'b0, {a[7:2], 4'h0}, {d, a[1:0]}, 1'b1);
    endtask

    task automatic t_mode_regs();
        mode_reg_write(dsr_pkg::MR_BANK_MASK, BANK_M);
        mode_reg_write(dsr_pkg::MR_SEG_MASK, SEG_M);
        mrr_chk(8'h10, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
        mrr_chk(8'h11, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
        mrr_chk(8'h20, 16'hFFFF, 16'h0000, 16'hFFFF, 16'h0000);
        mrr_chk(8'h28, 16'h0000, 16'h0000, 16'hFFFF, 16'hFFFF);
        $display("t_mode_regs done");
    endtask

    task automatic t_refresh_ptr();
        repeat (3) i_ctrl.send(1'b1, 1'b0, 10'h004, 10'h000, 1'b1);
        #1 chk(16'(pb_bank), 16'h0003);
        mrr_chk(8'h1F, 16'h0060, 16'h0000, 16'h0000, 16'h0000);
        $display("t_refresh_ptr done");
    endtask

    task automatic t_self_refresh();
        int i;
        i_ctrl.send(1'b0, 1'b0, 10'h004, 10'h000, 1'b0);
        #1 chk(16'(in_self_refresh), 16'h0001);
        fork
            begin
                i_ctrl.send(1'b0, 1'b0, 10'h088, 10'h000, 1'b0);
                repeat (4) @(posedge link_clk);
                #1 chk(16'(dq_out.oe), 16'h0000);
                i_ctrl.halt();
            end
            begin
                i = 0;
                while (i < 24 && refresh.pulse !== 1'b1)
                begin
                    @(negedge sys_clk);
                    i++;
                end
                chk(16'(refresh.pulse), 16'h0001);
                chk(16'(refresh.bank_en), {8'h00, ~BANK_M});
                chk(16'(refresh.seg_en), {8'h00, ~SEG_M});
            end
        join
        repeat (20) @(posedge sys_clk);
        i_ctrl.resume();
        repeat (2) i_ctrl.send(1'b0, 1'b1, 10'h000, 10'h000, 1'b0);
        i_ctrl.send(1'b1, 1'b1, 10'h000, 10'h000, 1'b1);
        #1 chk(16'(in_self_refresh), 16'h0000);
        chk(16'(pb_bank), 16'h0000);
        i_ctrl.send(1'b1, 1'b0, 10'h004, 10'h000, 1'b1);
        #1 chk(16'(pb_bank), 16'h0001);
        i_ctrl.send(1'b1, 1'b0, 10'h00C, 10'h000, 1'b1);
        #1 chk(16'(pb_bank), 16'h0000);
        $display("t_self_refresh done");
    endtask

    // Reset, then the scenarios
    initial
    begin
        rstn            = 1'b0;
        n_fail          = 0;
        samples_checked = 0;
        cyc             = 0;
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge link_clk);
        t_mode_regs();
        t_refresh_ptr();
        t_self_refresh();
        print_verdict();
    end
endmodule // tb_top
